// [src/misc_config_status.sv]
// Low bits of the bridge's misc configuration/status register, with the ISA clock divider.
// Assumes config cycles are decoded upstream and arrive as one-cycle strobes on mclk.
`timescale 1ns/1ps
`include "misc_cfg_map.svh"

// What this block does, and what software and the board must do (R3, R8)
// (R1) USB variant: bit 4 enables USB, resets 0; cleared keeps USB logic inactive.
// (R2) Function 2 config accesses are claimed only while USB enable is 1.
// (R3) Software sets USB enable at boot; disables function 2 command bits first.
// (R4) Non-USB variant: bit 2 drives header-type multifunction flag, resets to 1.
// (R5) Non-USB variant: bit 1 reports inverted terminal-count strap sampled at reset.
// (R6) Non-USB variant: bit 0 reports clock strap; 1 divides by 3, 0 by 4.
// (R7) USB variant: bit 0 writable divisor select, reset from clock strap.
// (R8) A 30 MHz bus clock requires divide-by-4, giving 7.5 MHz ISA clock.
// (R9) ISA clock is bus clock divided by selected divisor, changed glitch-free.
module misc_config_status #(
    parameter bit usb_variant = 1'b1
) (
    input wire logic mclk,
    input wire logic rst,
    input misc_cfg_pkg::cfg_req_type cfg_req,
    output misc_cfg_pkg::cfg_ans_type cfg_ans,
    input wire logic isa_terminal_count_in,
    input wire logic isa_bus_clock_in,
    output logic isa_bus_clock_out,
    output logic isa_bus_clock_oe_n,
    output logic usb_function_enable,
    output logic header_multifunction
);
    import misc_cfg_pkg::*;

    logic usb_en;
    logic hdr_mf;
    logic dma_strap;
    logic div_sel;
    logic div_active;
    logic [1:0] div_cnt;
    logic [1:0] div_last;
    logic [1:0] next_div_cnt;
    logic isa_clk;
    logic [15:0] rdata;
    logic [15:0] reg_view;

    // ****************************************************************
    // Register bits
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            usb_en <= `USB_EN_RST;
        end else if (usb_variant && cfg_req.write && cfg_req.byte_en[0]) begin
            usb_en <= cfg_req.wdata[`USB_EN_BIT]; // [R1]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hdr_mf <= `HDR_MF_RST;
        end else if (!usb_variant && cfg_req.write && cfg_req.byte_en[0]) begin
            hdr_mf <= cfg_req.wdata[`HDR_MF_BIT]; // [R4]
        end
    end

    // Straps are caught every reset cycle, so the last one before release sticks
    always_ff @(posedge mclk) begin
        if (rst) begin
            dma_strap <= ~isa_terminal_count_in; // [R5]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            div_sel <= isa_bus_clock_in; // [R6] [R7]
        end else if (usb_variant && cfg_req.write && cfg_req.byte_en[0]) begin
            div_sel <= cfg_req.wdata[`DIV_SEL_BIT]; // [R7]
        end
    end

    always_comb begin
        reg_view = 16'h0000;
        reg_view[`DIV_SEL_BIT] = div_sel;
        if (usb_variant) begin
            reg_view[`USB_EN_BIT] = usb_en;
        end else begin
            reg_view[`HDR_MF_BIT] = hdr_mf;
            reg_view[`DMA_STRAP_BIT] = dma_strap;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (cfg_req.read) begin
            rdata <= reg_view;
        end
    end

    assign usb_function_enable = usb_variant & usb_en; // [R1]
    assign header_multifunction = usb_variant | hdr_mf; // [R4]
    assign cfg_ans.rdata = rdata;
    assign cfg_ans.func2_claim = cfg_req.func2_req & usb_function_enable; // [R2]

    // ****************************************************************
    // ISA clock divider
    // ****************************************************************
    // New divisor is only adopted at a period boundary, so no runt pulse
    // Counter leaves reset at a period end, so the first high phase is whole
    assign div_last = (div_active == `DIV_SEL_BY3) ? `DIV_LAST_BY3 : `DIV_LAST_BY4;
    assign next_div_cnt = (div_cnt == div_last) ? 2'h0 : div_cnt + 2'h1;

    always_ff @(posedge mclk) begin
        if (rst) begin
            div_cnt <= `DIV_LAST_BY4;
        end else begin
            div_cnt <= next_div_cnt; // [R9]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            div_active <= 1'h0;
        end else if (div_cnt == div_last) begin
            div_active <= div_sel; // [R9] [R8]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            isa_clk <= 1'h0;
        end else begin
            isa_clk <= (next_div_cnt < `DIV_HIGH_CYCLES); // [R9]
        end
    end

    // Pin released during reset so the strap can be read
    assign isa_bus_clock_out = isa_clk;
    assign isa_bus_clock_oe_n = rst;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_usb_reset;
        @(posedge mclk) $fell(rst) |-> !usb_function_enable;
    endproperty
    a_usb_reset: assert property (p_usb_reset) else $error("usb enable not 0 after reset"); // [R1]

    property p_usb_write;
        @(posedge mclk) disable iff (rst)
        (usb_variant && cfg_req.write && cfg_req.byte_en[0])
        |=> usb_function_enable == $past(cfg_req.wdata[4]);
    endproperty
    a_usb_write: assert property (p_usb_write) else $error("usb enable write lost"); // [R1]

    property p_func2_gate;
        @(posedge mclk) disable iff (rst)
        cfg_ans.func2_claim |-> (cfg_req.func2_req && usb_en && usb_variant);
    endproperty
    a_func2_gate: assert property (p_func2_gate) else $error("function 2 claimed while off"); // [R2]

    property p_hdr_reset;
        @(posedge mclk) $fell(rst) |-> header_multifunction;
    endproperty
    a_hdr_reset: assert property (p_hdr_reset) else $error("multifunction flag not 1"); // [R4]

    property p_dma_read;
        @(posedge mclk) disable iff (rst)
        (!usb_variant && cfg_req.read) |=> cfg_ans.rdata[1] == dma_strap;
    endproperty
    a_dma_read: assert property (p_dma_read) else $error("dma strap misreported"); // [R5]

    property p_dma_stable;
        @(posedge mclk) disable iff (rst) 1'b1 |=> $stable(dma_strap);
    endproperty
    a_dma_stable: assert property (p_dma_stable) else $error("dma strap changed"); // [R5]

    property p_div_ro;
        @(posedge mclk) disable iff (rst) !usb_variant |=> $stable(div_sel);
    endproperty
    a_div_ro: assert property (p_div_ro) else $error("read-only divisor changed"); // [R6]

    property p_div_write;
        @(posedge mclk) disable iff (rst)
        (usb_variant && cfg_req.write && cfg_req.byte_en[0])
        |=> div_sel == $past(cfg_req.wdata[0]);
    endproperty
    a_div_write: assert property (p_div_write) else $error("divisor write lost"); // [R7]

    property p_clk_high;
        @(posedge mclk) disable iff (rst)
        $rose(isa_bus_clock_out) |=> isa_bus_clock_out ##1 !isa_bus_clock_out;
    endproperty
    a_clk_high: assert property (p_clk_high) else $error("isa clock high not 2 cycles"); // [R9]

    property p_clk_low;
        @(posedge mclk) disable iff (rst)
        $fell(isa_bus_clock_out) |-> ##[1:2] isa_bus_clock_out;
    endproperty
    a_clk_low: assert property (p_clk_low) else $error("isa clock low too long"); // [R9]

    property p_hdr_write;
        @(posedge mclk) disable iff (rst)
        (!usb_variant && cfg_req.write && cfg_req.byte_en[0])
        |=> header_multifunction == $past(cfg_req.wdata[`HDR_MF_BIT]);
    endproperty
    a_hdr_write: assert property (p_hdr_write) else $error("multifunction write lost"); // [R4]

    property p_usb_hold;
        @(posedge mclk) disable iff (rst)
        !cfg_req.write |=> $stable(usb_function_enable);
    endproperty
    a_usb_hold: assert property (p_usb_hold) else $error("usb enable changed unwritten"); // [R1]

    property p_dma_strap;
        @(posedge mclk) $fell(rst) |-> dma_strap == !$past(isa_terminal_count_in);
    endproperty
    a_dma_strap: assert property (p_dma_strap) else $error("dma strap not inverted pin"); // [R5]

    property p_div_strap;
        @(posedge mclk) $fell(rst) |-> div_sel == $past(isa_bus_clock_in);
    endproperty
    a_div_strap: assert property (p_div_strap) else $error("divisor not from strap"); // [R6] [R7]

    property p_rdata_hold;
        @(posedge mclk) disable iff (rst)
        !cfg_req.read |=> $stable(cfg_ans.rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed unread"); // [R6]

    property p_div_adopt;
        @(posedge mclk) disable iff (rst)
        (div_cnt != div_last) |=> $stable(div_active);
    endproperty
    a_div_adopt: assert property (p_div_adopt) else $error("divisor adopted mid period"); // [R9]

endmodule

// [src/misc_cfg_map.svh]
// Offsets, field positions, reset values and timing counts of the misc configuration register.
// Assumes inclusion by the package and the register module only.
`ifndef MISC_CFG_MAP_SVH
`define MISC_CFG_MAP_SVH

// ****************************************************************
// Field positions
// ****************************************************************
`define USB_EN_BIT 4
`define HDR_MF_BIT 2
`define DMA_STRAP_BIT 1
`define DIV_SEL_BIT 0

// ****************************************************************
// Reset values and header-type offset
// ****************************************************************
`define USB_EN_RST 1'h0
`define HDR_MF_RST 1'h1
`define HDR_TYPE_OFFSET 8'h0e

// ****************************************************************
// Clock divider
// ****************************************************************
`define DIV_SEL_BY3 1'h1
`define DIV_LAST_BY3 2'h2
`define DIV_LAST_BY4 2'h3
`define DIV_HIGH_CYCLES 2'h2

`endif

// [src/misc_cfg_pkg.sv]
// Types shared by the misc configuration register block.
// Assumes the map header is on the include path.
`include "misc_cfg_map.svh"

package misc_cfg_pkg;

    // Configuration access as seen from the bridge's config decoder
    typedef struct packed {
        logic write;
        logic read;
        logic [1:0] byte_en;
        logic [15:0] wdata;
        logic func2_req;
    } cfg_req_type;

    typedef struct packed {
        logic [15:0] rdata;
        logic func2_claim;
    } cfg_ans_type;

endpackage

// [dv/misc_config_status_test.sv]
// Self-checking bench for the misc configuration register, both variants side by side.
// Assumes the package and the design are compiled first; one 40 MHz clock.
`timescale 1ns/1ps
`define CHK(x, y) begin checks++; if ((x) !== (y)) begin miscompares++; \
    $display("BAD %0t value differs", $time); end end
module misc_config_status_test;
    import misc_cfg_pkg::*;
    logic mclk, rst, tc, ck;
    cfg_req_type req;
    cfg_ans_type ans_u, ans_n;
    logic clk_u, clk_n, oe_u, oe_n, usb_u, usb_n, hdr_u, hdr_n;
    int miscompares, checks, cycles;
    misc_config_status #(.usb_variant(1'b1)) i_dut (.mclk(mclk), .rst(rst), .cfg_req(req),
        .cfg_ans(ans_u), .isa_terminal_count_in(tc), .isa_bus_clock_in(ck),
        .isa_bus_clock_out(clk_u), .isa_bus_clock_oe_n(oe_u),
        .usb_function_enable(usb_u), .header_multifunction(hdr_u));
    misc_config_status #(.usb_variant(1'b0)) i_dut_nu (.mclk(mclk), .rst(rst), .cfg_req(req),
        .cfg_ans(ans_n), .isa_terminal_count_in(tc), .isa_bus_clock_in(ck),
        .isa_bus_clock_out(clk_n), .isa_bus_clock_oe_n(oe_n),
        .usb_function_enable(usb_n), .header_multifunction(hdr_n));
    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task wr(input logic [15:0] d, input logic be);
        @(posedge mclk);
        req.write <= 1'b1;
        req.byte_en <= {1'b0, be};
        req.wdata <= d;
        @(posedge mclk);
        req.write <= 1'b0;
        #1;
    endtask
    task rd;
        @(posedge mclk);
        req.read <= 1'b1;
        @(posedge mclk);
        req.read <= 1'b0;
        #1;
    endtask
    // Straps flip after release so a later resample would show
    task do_reset(input logic t, input logic c);
        @(posedge mclk);
        rst <= 1'b1;
        tc <= t;
        ck <= c;
        repeat (2) @(posedge mclk);
        `CHK(oe_u, 1'b1)
        `CHK(oe_n, 1'b1)
        rst <= 1'b0;
        tc <= ~t;
        ck <= ~c;
        #1;
    endtask
    // Rising edges of each ISA clock over 24 cycles: 8 for div3, 6 for div4
    task rates(output int nu, output int nn);
        logic pu, pn;
        nu = 0;
        nn = 0;
        repeat (8) @(posedge mclk);
        #1;
        pu = clk_u;
        pn = clk_n;
        repeat (24) begin
            @(posedge mclk);
            #1;
            nu += int'(clk_u && !pu);
            nn += int'(clk_n && !pn);
            pu = clk_u;
            pn = clk_n;
        end
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_straps;
        `CHK(usb_u, 1'b0)
        `CHK(hdr_n, 1'b1)
        `CHK(oe_u, 1'b0)
        rd;
        `CHK(ans_u.rdata, 16'h0001)
        `CHK(ans_n.rdata[2], 1'b1)
        `CHK(ans_n.rdata[1], 1'b0)
        `CHK(ans_n.rdata[0], 1'b1)
        $display("t_straps done");
    endtask
    task t_gate;
        @(posedge mclk);
        req.func2_req <= 1'b1;
        #1;
        `CHK(ans_u.func2_claim, 1'b0)
        wr(16'h0011, 1'b0);
        `CHK(usb_u, 1'b0)
        wr(16'h0011, 1'b1);
        `CHK(usb_u, 1'b1)
        `CHK(ans_u.func2_claim, 1'b1)
        `CHK(ans_n.func2_claim, 1'b0)
        `CHK(usb_n, 1'b0)
        `CHK(hdr_u, 1'b1)
        rd;
        `CHK(ans_u.rdata, 16'h0011)
        wr(16'h0000, 1'b1);
        `CHK(ans_u.func2_claim, 1'b0)
        `CHK(hdr_n, 1'b0)
        rd;
        `CHK(ans_n.rdata, 16'h0001)
        $display("t_gate done");
    endtask
    task t_clock;
        int nu, nn;
        rates(nu, nn);
        `CHK(nu, 6)
        `CHK(nn, 8)
        wr(16'h0001, 1'b1);
        rates(nu, nn);
        `CHK(nu, 8)
        $display("t_clock done");
    endtask
    task t_restrap;
        int nu, nn;
        do_reset(1'b0, 1'b0);
        rd;
        `CHK(ans_n.rdata, 16'h0006)
        `CHK(ans_u.rdata, 16'h0000)
        rates(nu, nn);
        `CHK(nn, 6)
        `CHK(nu, 6)
        $display("t_restrap done");
    endtask
    task end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            end_of_test;
        end
    end
    initial begin
        rst = 1'b1;
        req = '0;
        tc = 1'b1;
        ck = 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        tc <= 1'b0;
        ck <= 1'b0;
        @(posedge mclk);
        #1;
        t_straps;
        t_gate;
        t_clock;
        t_restrap;
        end_of_test;
    end
endmodule
